/* hw/dip_defines.svh */
`ifndef DIP_DEFINES_SVH
`define DIP_DEFINES_SVH

// ==================================================================
// converter word and midscale code
`define DIP_WORD_W 14
`define DIP_MIDSCALE 14'h2000
`define DIP_POS_MAX 14'h1fff
`define DIP_NEG_MIN 14'h2000

// ==================================================================
// half-band filter geometry
`define DIP_TAPS 43
`define DIP_HIST 22
`define DIP_CENTRE_IDX 18
`define DIP_CENTRE_POS 10
`define DIP_COEF_W 16
`define DIP_COEF_SHIFT 15
`define DIP_ACC_W 36

// ==================================================================
// odd coefficients h1..h21, signed, scaled by two to the fifteenth
`define DIP_H1 16'sh5108
`define DIP_H3 -16'sh19c8
`define DIP_H5 16'sh0e10
`define DIP_H7 -16'sh08fc
`define DIP_H9 16'sh060e
`define DIP_H11 -16'sh041a
`define DIP_H13 16'sh02bc
`define DIP_H15 -16'sh01c2
`define DIP_H17 16'sh010e
`define DIP_H19 -16'sh0096
`define DIP_H21 16'sh0046

// ==================================================================
// output phases inside one input word period of four cycles
`define DIP_PH_CENTRE 2'h0
`define DIP_PH_STUFF_A 2'h1
`define DIP_PH_SUM 2'h2
`define DIP_PH_STUFF_B 2'h3

`endif

/* hw/dip_pkg.sv */
package dip_pkg;
   // pair of complementary converter codes with its update strobe
   typedef struct packed {
      logic [13:0] true_code;
      logic [13:0] comp_code;
      logic update;
   } dip_dac_s;

   // the four digital modes
   typedef enum logic [1:0] {
      dip_base_plain,
      dip_base_stuff,
      dip_if_plain,
      dip_if_stuff
   } dip_mode_e;
endpackage

/* hw/dip_path.sv */
`timescale 1ns/1ns
`include "dip_defines.svh"
// How it works
// - each 14-bit word is captured on the rising edge of the data clock
// - the filter raises the rate by two: two samples per captured word
// - response select low gives low-pass, high gives high-pass
// - zero-stuff enable low disables stuffing, high enables it, independent of response
// - all four combinations of the two mode inputs work
// - without stuffing each filter sample reaches the converter at twice word rate
// - with stuffing the converter updates at four times word rate
// - straight binary: zeros give no true current, ones give no complement current
// - the filter is a 43-tap symmetric half-band FIR, even coefficients zero
// - high-pass comes from negating only the centre coefficient H(18)
// - with stuffing a midscale code follows every filter sample
module dip_path
   import dip_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // parallel data source pins
   input wire logic data_clk_pin,
   input wire logic [13:0] data_word,
   // static mode pins
   input wire logic filter_response_select,
   input wire logic zero_stuff_enable,
   // converter drive
   output dip_dac_s dac_out,
   output dip_mode_e mode
);

   // ==================================================================
   // helpers

   // offset binary to two's complement and back is one msb flip
   function automatic logic signed [13:0] flip_msb(input logic [13:0] v);
      flip_msb = {~v[13], v[12:0]};
   endfunction

   // clamp a wide signed value into the 14-bit signed range
   function automatic logic signed [13:0] sat14(input logic signed [`DIP_ACC_W-1:0] v);
      if (v > $signed({{(`DIP_ACC_W-14){1'b0}}, `DIP_POS_MAX}))
         sat14 = `DIP_POS_MAX;
      else if (v < $signed({{(`DIP_ACC_W-14){1'b1}}, `DIP_NEG_MIN}))
         sat14 = `DIP_NEG_MIN;
      else
         sat14 = v[13:0];
   endfunction

   // odd coefficient for pair k, k=0 nearest the centre
   function automatic logic signed [15:0] coef(input int k);
      case (k)
         0: coef = `DIP_H1;
         1: coef = `DIP_H3;
         2: coef = `DIP_H5;
         3: coef = `DIP_H7;
         4: coef = `DIP_H9;
         5: coef = `DIP_H11;
         6: coef = `DIP_H13;
         7: coef = `DIP_H15;
         8: coef = `DIP_H17;
         9: coef = `DIP_H19;
         default: coef = `DIP_H21;
      endcase
   endfunction

   // ==================================================================
   // pin synchronisers

   logic [2:0] clk_sync;
   logic [13:0] word_s1;
   logic [13:0] word_s2;
   logic [1:0] sel_sync;
   logic [1:0] stuff_sync;

   // data clock and word go through the same two stages so they stay aligned
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         clk_sync <= 3'h0;
         word_s1 <= `DIP_MIDSCALE;
         word_s2 <= `DIP_MIDSCALE;
      end
      else
      begin
         clk_sync <= {clk_sync[1:0], data_clk_pin};
         word_s1 <= data_word;
         word_s2 <= word_s1;
      end
   end

   // mode pins are static, still synchronised so a change cannot go metastable
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         sel_sync <= 2'h0;
         stuff_sync <= 2'h0;
      end
      else
      begin
         sel_sync <= {sel_sync[0], filter_response_select};
         stuff_sync <= {stuff_sync[0], zero_stuff_enable};
      end
   end

   logic high_pass;
   logic stuffing;
   logic capture;

   assign high_pass = sel_sync[1];
   assign stuffing = stuff_sync[1];
   // rising edge seen only from the second and third stages
   assign capture = clk_sync[1] & ~clk_sync[2];
   assign mode = dip_mode_e'({high_pass, stuffing});

   // ==================================================================
   // input history, newest in slot 0

   logic signed [13:0] hist [`DIP_HIST];

   // edge-triggered input register feeding the filter delay line
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         for (int i = 0; i < `DIP_HIST; i++)
            hist[i] <= 14'h0000;
      end
      else if (capture)
      begin
         hist[0] <= flip_msb(word_s2);
         for (int i = 1; i < `DIP_HIST; i++)
            hist[i] <= hist[i-1];
      end
   end

   // ==================================================================
   // half-band arithmetic

   logic signed [`DIP_ACC_W-1:0] acc;
   logic signed [13:0] odd_sample;
   logic signed [13:0] centre_sample;

   // 22 nonzero outer taps fold into 11 symmetric pairs; even taps are zero
   always_comb
   begin
      logic signed [14:0] pair;
      pair = 15'sh0000;
      acc = '0;
      for (int k = 0; k < `DIP_HIST / 2; k++)
      begin
         pair = 15'(hist[`DIP_CENTRE_POS - k]) + 15'(hist[`DIP_CENTRE_POS + 1 + k]);
         // widen both factors first so the product keeps every bit
         acc = acc + `DIP_ACC_W'(pair) * `DIP_ACC_W'(coef(k));
      end
   end

   assign odd_sample = sat14(acc >>> `DIP_COEF_SHIFT);
   // the centre tap alone; high-pass negates it and nothing else
   assign centre_sample = high_pass ? sat14(-`DIP_ACC_W'(hist[`DIP_CENTRE_POS]))
                                    : hist[`DIP_CENTRE_POS];

   // ==================================================================
   // output phase sequencer

   logic [1:0] phase;
   logic running;

   // four cycles per word; a late word simply leaves the last phase held
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         phase <= `DIP_PH_STUFF_B;
         running <= 1'b0;
      end
      else if (capture)
      begin
         phase <= `DIP_PH_CENTRE;
         running <= 1'b1;
      end
      else if (phase != `DIP_PH_STUFF_B)
      begin
         phase <= phase + 2'h1;
         running <= 1'b1;
      end
      else
         running <= 1'b0;
   end

   logic [13:0] next_code;
   logic next_update;

   // two filter samples per word, midscale after each of them when stuffing
   always_comb
   begin
      next_code = dac_out.true_code;
      next_update = 1'b0;
      if (running)
      begin
         case (phase)
            `DIP_PH_CENTRE:
            begin
               next_code = flip_msb(centre_sample);
               next_update = 1'b1;
            end
            `DIP_PH_SUM:
            begin
               next_code = flip_msb(odd_sample);
               next_update = 1'b1;
            end
            default:
            begin
               if (stuffing)
               begin
                  next_code = `DIP_MIDSCALE;
                  next_update = 1'b1;
               end
            end
         endcase
      end
   end

   // straight binary codes to the two current outputs
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         dac_out.true_code <= `DIP_MIDSCALE;
         dac_out.comp_code <= ~`DIP_MIDSCALE;
         dac_out.update <= 1'b0;
      end
      else
      begin
         dac_out.true_code <= next_code;
         dac_out.comp_code <= ~next_code;
         dac_out.update <= next_update;
      end
   end

endmodule // dip_path

/* verification/dip_path_assertions.sv */
`timescale 1ns/1ns
// ==================================================
// port checks for the interpolation path
module dip_path_checker
   import dip_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // source and mode pins
   input wire logic data_clk_pin,
   input wire logic [13:0] data_word,
   input wire logic filter_response_select,
   input wire logic zero_stuff_enable,
   // converter drive
   input wire dip_dac_s dac_out,
   input wire dip_mode_e mode
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   // short names; latency window absorbs the pin synchroniser
   wire logic upd = dac_out.update;
   wire logic [13:0] code = dac_out.true_code;
   wire logic stuff = (mode == dip_base_stuff) || (mode == dip_if_stuff);
   a_capture_seen: assert property ($rose(data_clk_pin) |-> ##[3:6] upd)
      else $error("no update after data clock rise");
   a_two_samples: assert property (
      $rose(data_clk_pin) && !stuff |-> ##[3:6] (upd ##1 !upd ##1 upd))
      else $error("plain mode pair of samples missing");
   a_stuff_mid: assert property (
      $rose(data_clk_pin) && stuff |-> ##[3:6]
      (upd ##1 (upd && code == 14'h2000) ##1 upd ##1 (upd && code == 14'h2000)))
      else $error("midscale stuffing sequence wrong");
   a_comp_inverse: assert property (dac_out.comp_code == ~code)
      else $error("complement code not inverse of true code");
   a_reset_idle: assert property (
      $fell(rst) |-> code == 14'h2000 && dac_out.comp_code == 14'h1fff && !upd)
      else $error("codes not midscale after reset");
   a_code_hold: assert property (!upd |-> $stable(code))
      else $error("code moved without update");
   a_plain_gap: assert property (upd && !stuff |=> !upd)
      else $error("back to back updates without stuffing");
   a_mode_sync: assert property (
      !$past(rst) && !$past(rst, 2) |-> mode ==
      dip_mode_e'({$past(filter_response_select, 2), $past(zero_stuff_enable, 2)}))
      else $error("mode does not follow mode pins");
   c_plain: cover property (upd && mode == dip_base_plain);
   c_base_stuff: cover property (upd && mode == dip_base_stuff && code == 14'h2000);
   c_if_plain: cover property (upd && mode == dip_if_plain);
   c_if_stuff: cover property (upd && mode == dip_if_stuff && code == 14'h2000);
endmodule // dip_path_checker

/* verification/dip_source.sv */
`timescale 1ns/1ns
// ==================================================
// parallel word source sharing the bench clock
module dip_source
(
   // bench clock
   input wire logic ref_clk,
   // pins toward the path
   output logic data_clk_pin,
   output logic [13:0] data_word
);
   initial
   begin
      data_clk_pin = 1'b0;
      data_word = 14'h0000;
   end
   // eight cycles a word; word held three cycles on each side of the rise
   task automatic send(input logic [13:0] w);
      @(negedge ref_clk);
      data_word = w;
      repeat (3) @(negedge ref_clk);
      data_clk_pin = 1'b1;
      repeat (3) @(negedge ref_clk);
      data_word = ~w; // stale word is not left on the bus
      @(negedge ref_clk);
      data_clk_pin = 1'b0;
   endtask
endmodule // dip_source

/* verification/tb.sv */
`timescale 1ns/1ns
`include "dip_defines.svh"
// ==================================================
// bench top: random words through all four modes
module tb
   import dip_pkg::*;
;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic filter_response_select = 1'b0;
   logic zero_stuff_enable = 1'b0;
   logic [13:0] word;
   logic [31:0] seed = 32'hd4cde4b1;
   wire logic data_clk_pin;
   wire logic [13:0] data_word;
   wire dip_dac_s dac_out;
   wire dip_mode_e mode;
   int num_errors = 0;
   int num_checks = 0;
   int hist [22] = '{default: 0};
   logic [13:0] exp_q [$];
   int coef [11] = '{`DIP_H1, `DIP_H3, `DIP_H5, `DIP_H7, `DIP_H9, `DIP_H11,
      `DIP_H13, `DIP_H15, `DIP_H17, `DIP_H19, `DIP_H21};
   always #20 ref_clk = ~ref_clk;
   dip_source src_u (.ref_clk(ref_clk), .data_clk_pin(data_clk_pin), .data_word(data_word));
   dip_path dut_u (.ref_clk(ref_clk), .rst(rst), .data_clk_pin(data_clk_pin),
      .data_word(data_word), .filter_response_select(filter_response_select),
      .zero_stuff_enable(zero_stuff_enable), .dac_out(dac_out), .mode(mode));
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   // saturate, then back to offset binary
   function automatic logic [13:0] to_code(input int v);
      if (v > 8191) v = 8191;
      if (v < -8192) v = -8192;
      return v[13:0] ^ 14'h2000;
   endfunction
   // model: shift history, queue every sample this word yields
   task automatic model_word(input logic [13:0] w);
      int acc;
      acc = 0;
      for (int i = 21; i > 0; i--)
         hist[i] = hist[i-1];
      hist[0] = $signed(w ^ 14'h2000);
      for (int k = 0; k < 11; k++)
         acc += coef[k] * (hist[10-k] + hist[11+k]);
      exp_q.push_back(to_code(filter_response_select ? -hist[10] : hist[10]));
      if (zero_stuff_enable) exp_q.push_back(14'h2000);
      exp_q.push_back(to_code(acc >>> 15));
      if (zero_stuff_enable) exp_q.push_back(14'h2000);
   endtask
   task automatic summarize();
      if (num_errors == 0 && num_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // every converter update is compared with the model queue
   always @(negedge ref_clk)
   begin
      if (!rst && dac_out.update === 1'b1)
      begin
         num_checks++;
         if (exp_q.size() == 0 || dac_out.true_code !== exp_q[0])
         begin
            num_errors++;
            $display("[FAIL] true_code expected %h seen %h",
               exp_q.size() ? exp_q[0] : 14'h0, dac_out.true_code);
         end
         num_checks++;
         if (exp_q.size() == 0 || dac_out.comp_code !== ~exp_q[0])
         begin
            num_errors++;
            $display("[FAIL] comp_code expected %h seen %h",
               exp_q.size() ? ~exp_q[0] : 14'h3fff, dac_out.comp_code);
         end
         if (exp_q.size() != 0) void'(exp_q.pop_front());
      end
   end
   initial
   begin
      repeat (12) @(posedge ref_clk);
      @(negedge ref_clk);
      rst = 1'b0;
      for (int m = 0; m < 4; m++)
      begin
         // modes change only while the stream is idle
         filter_response_select = m[1];
         zero_stuff_enable = m[0];
         repeat (4) @(negedge ref_clk);
         num_checks++;
         if (mode !== dip_mode_e'(m[1:0]))
         begin
            num_errors++;
            $display("[FAIL] mode expected %0d seen %0d", m[1:0], mode);
         end
         for (int n = 0; n < 14; n++)
         begin
            seed = xs(seed);
            word = seed[31:29] == 3'h0 ? 14'h0000 : (seed[31:29] == 3'h1 ? 14'h3fff : seed[13:0]);
            model_word(word);
            src_u.send(word);
         end
         repeat (10) @(negedge ref_clk);
      end
      num_checks++;
      if (exp_q.size() != 0)
      begin
         num_errors++;
         $display("[FAIL] pending samples expected 0 seen %0d", exp_q.size());
      end
      summarize();
   end
   // watchdog: about five times the expected run
   initial
   begin
      #100000;
      num_errors++;
      summarize();
   end
endmodule // tb
bind dip_path dip_path_checker chk_u (.ref_clk(ref_clk), .rst(rst), .data_clk_pin(data_clk_pin),
   .data_word(data_word), .filter_response_select(filter_response_select),
   .zero_stuff_enable(zero_stuff_enable), .dac_out(dac_out), .mode(mode));
